//--- hw/feacc_pkg.sv
// Purpose: shared constants for the far-end alarm code controller
// Assumes: 32-bit apb register bus, 6-bit alarm codes
// Notes:   offsets are byte addresses, one aligned word per register
package feacc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00; // transmit mode
  localparam logic [7:0] REG_TX_FIRST  = 8'h04; // first code slot
  localparam logic [7:0] REG_TX_SECOND = 8'h08; // second code slot
  localparam logic [7:0] REG_STATUS    = 8'h0c; // status and overflow
  localparam logic [7:0] REG_RX_DATA   = 8'h10; // receive fifo pop port

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ST_EMPTY    = 0;  // fifo holds no code
  localparam int ST_OVERFLOW = 1;  // sticky, write one to clear
  localparam int ST_DETECT   = 2;  // code detected
  localparam int ST_IDLE     = 3;  // alarm-code idle
  localparam int ST_TX_BUSY  = 4;  // code transmission running, counted or continuous
  localparam int ST_LEVEL    = 8;  // fifo fill level, three bits
  localparam logic [5:0] CODE_RESET = 6'h3f;   // code slots after reset
  localparam logic [1:0] MODE_RESET = 2'h0;    // idle after reset

  // ---------------------------------------------------------------
  // transmit modes as written to the control register
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_IDLE   = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_DUAL   = 2'h2;
  localparam logic [1:0] MODE_CONT   = 2'h3;

  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam int         CODE_W     = 6;      // code width
  localparam int         FIFO_DEPTH = 4;      // receive fifo entries
  localparam logic [3:0] CW_LAST    = 4'hf;   // last bit of 16-bit word
  localparam logic [3:0] CW_REPEAT  = 4'ha;   // codewords per slot
  localparam logic [1:0] DETECT_CNT = 2'h3;   // equal words to detect
  localparam logic [1:0] DIFF_CNT   = 2'h2;   // differing words to clear
  localparam logic [4:0] IDLE_ONES  = 5'h10;  // ones that mean idle

  // ---------------------------------------------------------------
  // transmit sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FEACC_TX_ONES,
    FEACC_TX_FIRST,
    FEACC_TX_SECOND,
    FEACC_TX_CONT
  } feacc_tx_state_t;

endpackage

//--- hw/feacc_rx_fifo.sv
// Purpose: four-entry receive code fifo
// Assumes: push and pop are single-cycle strobes on clk_i
// Notes:   push when full is dropped, pop when empty is ignored
`timescale 1ns/100ps
module feacc_rx_fifo (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       push_i,
  input  wire logic [5:0] push_data_i,
  input  wire logic       pop_i,
  output logic      [5:0] head_o,
  output logic            empty_o,
  output logic      [2:0] level_o,
  output logic            overflow_o
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  logic [5:0] mem [feacc_pkg::FIFO_DEPTH]; // code storage
  logic [1:0] wr_ptr;                      // next write slot
  logic [1:0] rd_ptr;                      // oldest entry
  logic [2:0] count;                       // entries held
  logic       full;                        // no room left
  logic       do_push;                     // accepted write
  logic       do_pop;                      // accepted read

  assign full    = (count == 3'(feacc_pkg::FIFO_DEPTH));
  assign empty_o = (count == 3'h0);
  assign do_push = push_i && !full;
  assign do_pop  = pop_i && !empty_o;   // [RL17]
  assign head_o  = mem[rd_ptr];
  assign level_o = count;

  // write side
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count  <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      // fill level tracks both strobes in the same cycle
      if (do_push && !do_pop) begin
        count <= count + 3'h1;  // [RL15]
      end else if (do_pop && !do_push) begin
        count <= count - 3'h1;
      end
    end
  end

  // overflow pulse: a code arrived while full and was discarded
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= push_i && full;  // [RL16]
    end
  end

endmodule

//--- hw/feacc_top.sv
// Purpose: far-end alarm code transmitter, receiver and apb registers
// Assumes: line clock and rx data are asynchronous pins, sampled by clk_i
// Notes:   tx bit changes on line clock fall, rx bit taken on its rise
//
// Summary of operation
// (RL1) two writable 6-bit transmit code slots
// (RL2) code bit 1 in register bit 0
// (RL3) codes shifted out least significant first
// (RL4) codeword is 0, code, 0, eight ones
// (RL5) idle mode sends continuous ones
// (RL6) single mode: first slot ten times, ones
// (RL7) dual mode: first ten, second ten, ones
// (RL8) continuous mode repeats first slot until changed
// (RL9) search every bit slot for codeword boundary
// (RL10) three equal clean codewords set detect, push
// (RL11) fifo data bit 0 holds code bit 1
// (RL12) two differing codewords or idle clear detect
// (RL13) sixteen consecutive ones declare idle
// (RL14) idle ends when detect becomes set
// (RL15) four-entry fifo with level and empty status
// (RL16) push while full discarded, overflow declared
// (RL17) pop while empty ignored
// (RL18) line side writes fifo, software reads it
// (RL19) fifo works while other side inactive
// (RL20) code bit 1 sent first, mirrored on receive
// (RL21) overflow latched, indications readable by software
`timescale 1ns/100ps
module feacc_top (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // overhead bit stream
  input  wire logic        line_clk_i,
  input  wire logic        rx_data_i,
  output logic             tx_data_o
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // builds the 16-bit codeword, bit 15 is sent first
  function automatic logic [15:0] make_word(input logic [5:0] code);
    make_word = {1'b0, code[0], code[1], code[2], code[3], code[4],
                 code[5], 1'b0, 8'hff};  // [RL4] [RL20]
  endfunction

  // mirrors a code between signal order and register order
  function automatic logic [5:0] flip6(input logic [5:0] v);
    flip6 = {v[0], v[1], v[2], v[3], v[4], v[5]};
  endfunction

  // ---------------------------------------------------------------
  // registers and shared signals
  // ---------------------------------------------------------------
  logic [5:0]  tx_code_first_slot;   // first code, bit 0 sent first
  logic [5:0]  tx_code_second_slot;  // second code
  logic [1:0]  tx_mode;              // transmit mode field
  logic        overflow;             // sticky overflow flag
  logic        wr_en;                // apb write in access phase
  logic        rd_en;                // apb read in access phase
  logic        setup;                // apb setup cycle
  logic        mapped;               // address hits a register
  logic        mode_wr;              // control register written
  logic [5:0]  fifo_head;            // oldest code in fifo
  logic        fifo_empty;           // fifo holds nothing
  logic [2:0]  fifo_level;           // entries held
  logic        fifo_ovf;             // overflow pulse from fifo
  logic        fifo_pop;             // software pop strobe
  logic        code_push;            // receiver push strobe
  logic [5:0]  code_data;            // code to push, register order

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign setup    = psel_i && !penable_i;
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_en    = psel_i && penable_i && !pwrite_i;
  assign mode_wr  = wr_en && (paddr_i == feacc_pkg::REG_CTRL);
  assign pready_o = 1'b1;  // every access ends in its first access cycle
  assign mapped   = (paddr_i == feacc_pkg::REG_CTRL)
                 || (paddr_i == feacc_pkg::REG_TX_FIRST)
                 || (paddr_i == feacc_pkg::REG_TX_SECOND)
                 || (paddr_i == feacc_pkg::REG_STATUS)
                 || (paddr_i == feacc_pkg::REG_RX_DATA);
  assign pslverr_o = psel_i && penable_i && !mapped;
  // a read of the fifo port pops one code, ignored inside the fifo if empty
  assign fifo_pop = rd_en && (paddr_i == feacc_pkg::REG_RX_DATA); // [RL18]

  // writable registers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_code_first_slot  <= feacc_pkg::CODE_RESET;
      tx_code_second_slot <= feacc_pkg::CODE_RESET;
      tx_mode             <= feacc_pkg::MODE_RESET;
    end else if (wr_en) begin
      case (paddr_i)
        feacc_pkg::REG_CTRL: begin
          tx_mode <= pwdata_i[1:0];
        end
        feacc_pkg::REG_TX_FIRST: begin
          tx_code_first_slot <= pwdata_i[5:0];  // [RL1] [RL2]
        end
        feacc_pkg::REG_TX_SECOND: begin
          tx_code_second_slot <= pwdata_i[5:0];  // [RL1] [RL2]
        end
        default: begin
        end
      endcase
    end
  end

  // sticky overflow, a new overflow wins over the clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      overflow <= 1'b0;
    end else if (fifo_ovf) begin
      overflow <= 1'b1;  // [RL16] [RL21]
    end else if (wr_en && (paddr_i == feacc_pkg::REG_STATUS)
                 && pwdata_i[feacc_pkg::ST_OVERFLOW]) begin
      overflow <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // line pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [2:0] lclk_sync;  // line clock, first two stages synchronise
  logic [1:0] rxd_sync;   // rx data synchroniser
  logic       lclk_rise;  // line clock rising edge seen
  logic       lclk_fall;  // line clock falling edge seen

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      lclk_sync <= 3'h0;
      rxd_sync  <= 2'h3;
    end else begin
      lclk_sync <= {lclk_sync[1:0], line_clk_i};
      rxd_sync  <= {rxd_sync[0], rx_data_i};
    end
  end

  assign lclk_rise = lclk_sync[1] && !lclk_sync[2];
  assign lclk_fall = !lclk_sync[1] && lclk_sync[2];

  // ---------------------------------------------------------------
  // transmit sequencer
  // ---------------------------------------------------------------
  feacc_pkg::feacc_tx_state_t tx_state;  // sequencer state
  logic [3:0]  tx_bit;                   // bit index in codeword
  logic [3:0]  tx_words;                 // codewords sent in slot
  logic [15:0] tx_word;                  // word being sent

  assign tx_word = (tx_state == feacc_pkg::FEACC_TX_SECOND)
                 ? make_word(tx_code_second_slot)
                 : make_word(tx_code_first_slot);

  // mode write restarts the sequence; counting advances on line falls
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_state <= feacc_pkg::FEACC_TX_ONES;
      tx_bit   <= 4'h0;
      tx_words <= 4'h0;
    end else if (mode_wr) begin
      tx_bit   <= 4'h0;
      tx_words <= 4'h0;
      case (pwdata_i[1:0])
        feacc_pkg::MODE_SINGLE: tx_state <= feacc_pkg::FEACC_TX_FIRST;
        feacc_pkg::MODE_DUAL:   tx_state <= feacc_pkg::FEACC_TX_FIRST;
        feacc_pkg::MODE_CONT:   tx_state <= feacc_pkg::FEACC_TX_CONT;
        default:                tx_state <= feacc_pkg::FEACC_TX_ONES;
      endcase
    end else if (lclk_fall && tx_state != feacc_pkg::FEACC_TX_ONES) begin
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == feacc_pkg::CW_LAST) begin
        case (tx_state)
          feacc_pkg::FEACC_TX_FIRST: begin
            if (tx_words == feacc_pkg::CW_REPEAT - 4'h1) begin
              tx_words <= 4'h0;
              // dual goes on to the second slot, single stops
              if (tx_mode == feacc_pkg::MODE_DUAL) begin
                tx_state <= feacc_pkg::FEACC_TX_SECOND;  // [RL7]
              end else begin
                tx_state <= feacc_pkg::FEACC_TX_ONES;    // [RL6]
              end
            end else begin
              tx_words <= tx_words + 4'h1;
            end
          end
          feacc_pkg::FEACC_TX_SECOND: begin
            if (tx_words == feacc_pkg::CW_REPEAT - 4'h1) begin
              tx_words <= 4'h0;
              tx_state <= feacc_pkg::FEACC_TX_ONES;      // [RL7]
            end else begin
              tx_words <= tx_words + 4'h1;
            end
          end
          feacc_pkg::FEACC_TX_CONT: begin
            tx_state <= feacc_pkg::FEACC_TX_CONT;        // [RL8]
          end
          default: begin
            tx_state <= feacc_pkg::FEACC_TX_ONES;
          end
        endcase
      end
    end
  end

  // serial output, changed on line falls so the far end samples on rise
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_data_o <= 1'b1;
    end else if (lclk_fall) begin
      if (tx_state == feacc_pkg::FEACC_TX_ONES) begin
        tx_data_o <= 1'b1;                      // [RL5]
      end else begin
        tx_data_o <= tx_word[4'hf - tx_bit];    // [RL3] [RL20]
      end
    end
  end

  // ---------------------------------------------------------------
  // receive framing
  // ---------------------------------------------------------------
  logic [15:0] rx_sr;      // last 16 received bits, newest at bit 0
  logic [15:0] next_sr;    // shift register after this bit
  logic        rx_match;   // codeword sequence at this slot
  logic        rx_locked;  // boundary known
  logic [3:0]  rx_pos;     // bits since last boundary
  logic        cw_ok;      // clean codeword boundary this bit
  logic        cw_err;     // expected boundary missing
  logic [5:0]  cw_code;    // code of clean word, register order
  logic [4:0]  ones_cnt;   // consecutive ones received

  assign next_sr  = {rx_sr[14:0], rxd_sync[1]};
  assign rx_match = !next_sr[15] && !next_sr[8]
                 && (next_sr[7:0] == 8'hff);       // [RL9]
  assign cw_ok    = lclk_rise && rx_match;
  assign cw_err   = lclk_rise && !rx_match && rx_locked
                 && (rx_pos == feacc_pkg::CW_LAST);
  assign cw_code  = flip6(next_sr[14:9]);           // [RL11] [RL20]

  // shift in on each line rise, track the boundary
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_sr     <= 16'hffff;
      rx_locked <= 1'b0;
      rx_pos    <= 4'h0;
    end else if (lclk_rise) begin
      rx_sr  <= next_sr;
      rx_pos <= rx_match ? 4'h0 : rx_pos + 4'h1;
      if (rx_match) begin
        rx_locked <= 1'b1;
      end else if (cw_err) begin
        rx_locked <= 1'b0;  // search every slot again
      end
    end
  end

  // ---------------------------------------------------------------
  // detection, idle and fifo push
  // ---------------------------------------------------------------
  logic [5:0] last_code;  // code of previous clean word
  logic [1:0] same_cnt;   // equal clean words in a row
  logic [1:0] diff_cnt;   // differing words in a row
  logic [5:0] cur_code;   // detected code
  logic       detected;   // code-detected indication
  logic       idle;       // alarm-code idle indication
  logic       hit3;       // third equal clean word now
  logic       idle_hit;   // sixteenth one now

  assign hit3     = cw_ok && (cw_code == last_code)
                 && (same_cnt == feacc_pkg::DETECT_CNT - 2'h1);
  assign idle_hit = lclk_rise && rxd_sync[1]
                 && (ones_cnt == feacc_pkg::IDLE_ONES - 5'h1);
  assign code_push = hit3 && !detected;             // [RL10] [RL18]
  assign code_data = cw_code;

  // counts equal clean words, an error word breaks the run
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      last_code <= 6'h0;
      same_cnt  <= 2'h0;
    end else if (cw_ok) begin
      last_code <= cw_code;
      if (cw_code != last_code) begin
        same_cnt <= 2'h1;
      end else if (same_cnt != feacc_pkg::DETECT_CNT) begin
        same_cnt <= same_cnt + 2'h1;
      end
    end else if (cw_err) begin
      same_cnt <= 2'h0;
    end
  end

  // consecutive ones for idle detection
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ones_cnt <= 5'h0;
    end else if (lclk_rise) begin
      if (!rxd_sync[1]) begin
        ones_cnt <= 5'h0;
      end else if (ones_cnt != feacc_pkg::IDLE_ONES) begin
        ones_cnt <= ones_cnt + 5'h1;               // [RL13]
      end
    end
  end

  // code-detected indication and differing-word counter
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      detected <= 1'b0;
      cur_code <= 6'h0;
      diff_cnt <= 2'h0;
    end else if (code_push) begin
      detected <= 1'b1;                            // [RL10]
      cur_code <= cw_code;
      diff_cnt <= 2'h0;
    end else if (idle_hit) begin
      detected <= 1'b0;                            // [RL12]
      diff_cnt <= 2'h0;
    end else if (detected && (cw_err || (cw_ok && cw_code != cur_code)))
    begin
      if (diff_cnt == feacc_pkg::DIFF_CNT - 2'h1) begin
        detected <= 1'b0;                          // [RL12]
        diff_cnt <= 2'h0;
      end else begin
        diff_cnt <= diff_cnt + 2'h1;
      end
    end else if (cw_ok) begin
      diff_cnt <= 2'h0;
    end
  end

  // idle indication, ended when detection is set
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      idle <= 1'b0;
    end else if (code_push) begin
      idle <= 1'b0;                                // [RL14]
    end else if (idle_hit) begin
      idle <= 1'b1;                                // [RL13]
    end
  end

  // ---------------------------------------------------------------
  // receive fifo, single clock so either side runs without the other
  // ---------------------------------------------------------------
  feacc_rx_fifo u_fifo (                           // [RL19]
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .push_i      (code_push),
    .push_data_i (code_data),
    .pop_i       (fifo_pop),
    .head_o      (fifo_head),
    .empty_o     (fifo_empty),
    .level_o     (fifo_level),
    .overflow_o  (fifo_ovf)
  );

  // ---------------------------------------------------------------
  // read data, captured in the setup cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h0;
    end else if (setup) begin
      prdata_o <= 32'h0;
      case (paddr_i)
        feacc_pkg::REG_CTRL:      prdata_o[1:0] <= tx_mode;
        feacc_pkg::REG_TX_FIRST:  prdata_o[5:0] <= tx_code_first_slot;
        feacc_pkg::REG_TX_SECOND: prdata_o[5:0] <= tx_code_second_slot;
        feacc_pkg::REG_STATUS: begin
          prdata_o[feacc_pkg::ST_EMPTY]    <= fifo_empty;  // [RL15]
          prdata_o[feacc_pkg::ST_OVERFLOW] <= overflow;    // [RL21]
          prdata_o[feacc_pkg::ST_DETECT]   <= detected;    // [RL21]
          prdata_o[feacc_pkg::ST_IDLE]     <= idle;        // [RL21]
          prdata_o[feacc_pkg::ST_TX_BUSY]  <=
            (tx_state != feacc_pkg::FEACC_TX_ONES);
          prdata_o[feacc_pkg::ST_LEVEL +: 3] <= fifo_level;
        end
        feacc_pkg::REG_RX_DATA: begin
          // an empty fifo reads zero
          prdata_o[5:0] <= fifo_empty ? 6'h0 : fifo_head;
        end
        default: begin
        end
      endcase
    end
  end

endmodule

//--- tb/feacc_asserts.sv
// Purpose: port-level checks for the alarm code controller
// Assumes: one clock domain, zero-wait apb slave
// Notes:   bound at the foot of this file
`timescale 1ns/100ps
module feacc_asserts (
  input logic        clk_i,
  input logic        reset_n_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [7:0]  paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  input logic        line_clk_i,
  input logic        rx_data_i,
  input logic        tx_data_o
);
  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire acc = psel_i && penable_i; // access phase
  wire rd  = acc && !pwrite_i; // read access
  wire hit = paddr_i[1:0] == 2'h0 && paddr_i <= 8'h10;
  wire ctl = acc && pwrite_i && paddr_i == feacc_pkg::REG_CTRL;
  wire sts = rd && paddr_i == feacc_pkg::REG_STATUS;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ready_high: assert property (psel_i |-> pready_o)
    else $error("ready low in a transfer");
  chk_err_unmapped: assert property (acc && !hit |-> pslverr_o)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (acc && hit |-> !pslverr_o)
    else $error("error on mapped address");
  chk_rdata_zero: assert property (rd && !hit |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_stands: assert property (acc |=> $stable(prdata_o))
    else $error("read data moved");
  chk_status_shape: assert property (sts |-> prdata_o[31:11] == 21'h0
    && prdata_o[0] == (prdata_o[10:8] == 3'h0) && prdata_o[10:8] <= 3'h4)
    else $error("status fields disagree");
  chk_detect_idle: assert property (sts |-> !(prdata_o[2] && prdata_o[3]))
    else $error("detect and idle both set");
  chk_code_width: assert property (rd && paddr_i == feacc_pkg::REG_RX_DATA
    |-> prdata_o[31:6] == 26'h0)
    else $error("fifo data above code width");
  chk_tx_starts: assert property (ctl && pwdata_i[1:0] != 2'h0
    |-> ##[1:24] !tx_data_o)
    else $error("no leading codeword zero");
  chk_tx_idle: assert property (ctl && pwdata_i[1:0] == 2'h0
    |-> ##[1:24] tx_data_o [*8])
    else $error("idle not sending ones");
endmodule

bind feacc_top feacc_asserts i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .line_clk_i(line_clk_i),
  .rx_data_i(rx_data_i), .tx_data_o(tx_data_o));

//--- tb/feacc_line_model.sv
// Purpose: far end of the overhead link, line clock and rx stream
// Assumes: rx changes on line clock fall, idle line is ones
// Notes:   run low freezes the line clock
`timescale 1ns/100ps
module feacc_line_model (
  output logic line_clk_o,
  output logic rx_data_o
);
  logic run; // line clock enable
  // 160 ns line clock, offset from the system clock
  initial begin
    line_clk_o = 1'b0;
    rx_data_o  = 1'b1;
    run        = 1'b1;
    #3;
    forever begin
      #80;
      if (run) line_clk_o = ~line_clk_o;
    end
  end
  // one bit of a codeword, code bit 1 taken from bit 0
  function automatic logic cw_bit(input logic [5:0] code, input int pos);
    return (pos == 0 || pos == 7) ? 1'b0 : (pos < 7) ? code[pos-1] : 1'b1;
  endfunction
  // send n whole codewords back to back
  task automatic send(input logic [5:0] code, input int n);
    for (int i = 0; i < n * 16; i++) begin
      @(negedge line_clk_o);
      rx_data_o <= cw_bit(code, i % 16);
    end
  endtask
endmodule

//--- tb/test_far_end_alarm_code_controller.sv
// Purpose: self-checking bench for the alarm code controller
// Assumes: 160 ns line clock from the partner model
// Notes:   registers reached over apb, no random stimulus
`timescale 1ns/100ps
module test_far_end_alarm_code_controller;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        lclk, rxd, txd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          n_mismatch, checks;
  localparam logic [5:0] CODES [5] = '{6'h13, 6'h2d, 6'h0c, 6'h21, 6'h3e};
  localparam logic [7:0] STS_A = feacc_pkg::REG_STATUS;
  feacc_top i_dut (.clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .line_clk_i(lclk), .rx_data_i(rxd),
    .tx_data_o(txd));
  feacc_line_model i_line (.line_clk_o(lclk), .rx_data_o(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until ready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  // reset values, slots, unmapped and empty reads
  task automatic t_regs;
    rd(STS_A, 32'h1);
    rd(feacc_pkg::REG_TX_FIRST, 32'h3f);
    wr(feacc_pkg::REG_TX_FIRST, 32'(CODES[0]));
    wr(feacc_pkg::REG_TX_SECOND, 32'(CODES[1]));
    wr(8'h14, 32'h5);
    rd(feacc_pkg::REG_TX_SECOND, 32'(CODES[1]));
    rd(8'h14, 32'h0);
    rd(feacc_pkg::REG_RX_DATA, 32'h0);
    rd(STS_A, 32'h1);
  endtask
  // mode m, nb bits compared, then idle ones
  task automatic t_tx(input logic [1:0] m, input int nb);
    int k = 0, w;
    logic e;
    wr(feacc_pkg::REG_CTRL, 32'(m));
    do @(posedge lclk); while (txd !== 1'b0 && ++k < 40);
    for (int i = 0; i < nb; i++) begin
      w = i / 16;
      e = i_line.cw_bit(w >= 10 && m == 2'h2 ? CODES[1] : CODES[0], i % 16);
      if (m != 2'h3 && w >= (m == 2'h2 ? 20 : 10)) e = 1'b1;
      if (i > 0) @(posedge lclk);
      chk(32'(txd), 32'(e));
    end
    wr(feacc_pkg::REG_CTRL, 32'h0);
    repeat (40) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      @(posedge lclk);
      chk(32'(txd), 32'h1);
    end
  endtask
  // detect, clear, idle, overflow, drain with line stopped
  task automatic t_rx;
    rd(STS_A, 32'h9);
    i_line.send(CODES[0], 3);
    repeat (30) @(posedge clk);
    rd(STS_A, 32'h104);
    fork
      i_line.send(CODES[1], 3);
      begin
        repeat (542) @(posedge clk);
        rd(STS_A, 32'h100);
      end
    join
    repeat (30) @(posedge clk);
    rd(STS_A, 32'h204);
    repeat (700) @(posedge clk);
    rd(STS_A, 32'h208);
    for (int i = 2; i < 5; i++) i_line.send(CODES[i], 3);
    repeat (30) @(posedge clk);
    rd(STS_A, 32'h406);
    i_line.run = 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h10, 32'(CODES[i]));
    rd(feacc_pkg::REG_RX_DATA, 32'h0);
    rd(STS_A, 32'h7);
    wr(STS_A, 32'h2);
    rd(STS_A, 32'h5);
    i_line.run = 1'b1;
  endtask
  task automatic end_of_test;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, run needs about 190 us
  initial begin
    #500000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_tx(feacc_pkg::MODE_SINGLE, 176);
    t_tx(feacc_pkg::MODE_DUAL, 336);
    t_tx(feacc_pkg::MODE_CONT, 320);
    t_rx;
    end_of_test;
  end
endmodule
